// ---- rtl/pmoc_map.svh ----
// Register map, reset values, field codes and fixed exponent
`ifndef PMOC_MAP_SVH
`define PMOC_MAP_SVH
`define PMOC_OPERATION_ADDR  8'h01
`define PMOC_OPERATION_RESET 8'h00
`define PMOC_ON_OFF_ADDR     8'h02
`define PMOC_ON_OFF_RESET    8'h17
`define PMOC_VSEL_NOM        2'b00
`define PMOC_VSEL_LOW        2'b01
`define PMOC_VSEL_HIGH       2'b10
`define PMOC_MFLT_IGNORE     2'b01
`define PMOC_MFLT_ACT        2'b10
`define PMOC_FIXED_EXP       (-13)
`endif

// ---- rtl/pmoc_pkg.sv ----
// Types shared by the operation control block
package pmoc_pkg;
	typedef struct packed {
		logic       on_req;
		logic       soft_off;
		logic [1:0] vsel;
		logic [1:0] margin_flt;
		logic [1:0] unused;
	} pmoc_operation_t;

	typedef struct packed {
		logic       wr;
		logic       rd;
		logic [7:0] addr;
		logic [7:0] data;
	} pmoc_cmd_t;

	typedef enum logic [1:0] {
		PMOC_OFF,
		PMOC_RAMP_DOWN,
		PMOC_ON
	} pmoc_state_t;
endpackage

// ---- rtl/pmoc_operation_control.sv ----
// Operation byte interpreter with on/off qualification and shadow settings
`timescale 1ns/1ns
`include "pmoc_map.svh"
module pmoc_operation_control #(
	parameter int SHADOW_W = 16          // Width of after-disable setting
) (
	input  wire logic              clk_i,         // 50 MHz clock
	input  wire logic              reset_i,       // Async reset, high
	input  wire pmoc_pkg::pmoc_cmd_t cmd_i,       // Decoded command access
	input  wire logic              en_pin_i,      // Enable pin, async
	input  wire logic              ramp_done_i,   // Turn-off ramp finished
	input  wire logic [SHADOW_W-1:0] shadow_i,    // After-disable setting
	output logic [7:0]             rd_data_o,     // Read answer
	output logic                   rd_valid_o,    // Read answer strobe
	output logic                   out_en_o,      // Output enabled
	output logic                   pwm_tri_o,     // PWM held at tri-state
	output logic                   soft_off_o,    // Ramp-down in progress
	output logic [1:0]             vsel_o,        // Voltage target select
	output logic                   margin_act_o,  // Act on margin faults
	output logic [SHADOW_W-1:0]    active_cfg_o   // Active setting
);
	import pmoc_pkg::*;

	// All checks run on the one clock, off during reset
	default clocking cb_chk @(posedge clk_i); endclocking
	default disable iff (reset_i);

	// Elaboration check: a zero-width setting cannot be held
	if (SHADOW_W < 1) begin : g_bad_width
		$error("SHADOW_W must be positive");
	end

	pmoc_operation_t op, next_op;
	logic [7:0]      cfg, next_cfg;
	logic [1:0]      en_sync;
	pmoc_state_t     state, next_state;
	logic [7:0]      next_rd_data;
	logic            next_rd_valid;
	logic [SHADOW_W-1:0] next_active;
	logic            run_req;
	logic            next_soft_off;
	logic            next_vsel_ok;
	logic [1:0]      next_vsel;
	logic            next_margin_act;
	logic            next_out_en;
	logic            next_pwm_tri;

	// Pin is asynchronous; only the second flop is read
	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			en_sync <= 2'b00;
		end else begin
			en_sync <= {en_sync[0], en_pin_i};
		end
	end

	always_comb begin
		next_op = op;
		next_cfg = cfg;
		// Byte written whole, low bits forced
		if (cmd_i.wr && cmd_i.addr == `PMOC_OPERATION_ADDR) begin
			next_op = pmoc_operation_t'({cmd_i.data[7:2], 2'b00});
		end
		if (cmd_i.wr && cmd_i.addr == `PMOC_ON_OFF_ADDR) begin
			next_cfg = cmd_i.data;
		end
	end

	always_comb begin
		next_rd_valid = cmd_i.rd;
		next_rd_data = 8'h00;
		if (cmd_i.rd) begin
			case (cmd_i.addr)
				// Last written value, not live state
				`PMOC_OPERATION_ADDR: next_rd_data = op;
				`PMOC_ON_OFF_ADDR: next_rd_data = cfg;
				default: next_rd_data = 8'h00;
			endcase
		end
	end

	always_comb begin
		// Qualify on request by config and pin
		run_req = 1'b1;
		if (cfg[4]) begin
			if (cfg[3] && !op.on_req) run_req = 1'b0;
			if (cfg[2] && !en_sync[1]) run_req = 1'b0;
		end
		next_state = state;
		case (state)
			PMOC_OFF: begin
				if (run_req) next_state = PMOC_ON;
			end
			PMOC_ON: begin
				// Soft off only when bit 6 set
				if (!run_req) begin
					if (op.soft_off && !op.on_req && cfg[3])
						next_state = PMOC_RAMP_DOWN;
					else
						next_state = PMOC_OFF;
				end
			end
			PMOC_RAMP_DOWN: begin
				// Request back on aborts the ramp
				if (run_req) next_state = PMOC_ON;
				else if (ramp_done_i) next_state = PMOC_OFF;
			end
			default: next_state = PMOC_OFF;
		endcase
		// Shadow copied on entry to disabled
		next_active = active_cfg_o;
		if (state != PMOC_OFF && next_state == PMOC_OFF)
			next_active = shadow_i;
		// Immediate off tri-states PWM same edge
		next_out_en = (next_state != PMOC_OFF);
		next_pwm_tri = (next_state == PMOC_OFF);
		next_soft_off = (next_state == PMOC_RAMP_DOWN);
		next_vsel_ok = (next_op.vsel != 2'b11);
		next_vsel = next_vsel_ok ? next_op.vsel : vsel_o;
		// Only code 10 acts; unused keeps previous
		if (next_op.margin_flt == `PMOC_MFLT_ACT)
			next_margin_act = 1'b1;
		else if (next_op.margin_flt == `PMOC_MFLT_IGNORE)
			next_margin_act = 1'b0;
		else
			next_margin_act = margin_act_o;
	end

	always_ff @(posedge clk_i or posedge reset_i) begin
		if (reset_i) begin
			op <= pmoc_operation_t'(`PMOC_OPERATION_RESET);
			cfg <= `PMOC_ON_OFF_RESET;
			state <= PMOC_OFF;
			rd_data_o <= 8'h00;
			rd_valid_o <= 1'b0;
			out_en_o <= 1'b0;
			// Nothing switches before a command or the enable pin
			pwm_tri_o <= 1'b1;
			soft_off_o <= 1'b0;
			vsel_o <= `PMOC_VSEL_NOM;
			margin_act_o <= 1'b0;
			active_cfg_o <= '0;
		end else begin
			op <= next_op;
			cfg <= next_cfg;
			state <= next_state;
			rd_data_o <= next_rd_data;
			rd_valid_o <= next_rd_valid;
			out_en_o <= next_out_en;
			pwm_tri_o <= next_pwm_tri;
			soft_off_o <= next_soft_off;
			vsel_o <= next_vsel;
			margin_act_o <= next_margin_act;
			active_cfg_o <= next_active;
		end
	end

	// Checks
	op_low_zero_a: assert property (
		op.unused == 2'b00) else $error("operation low bits not zero");

	sequence s_wr_op;
		cmd_i.wr && cmd_i.addr == `PMOC_OPERATION_ADDR;
	endsequence

	// Back-to-back write then read of the operation byte
	sequence s_rd_op;
		cmd_i.rd && cmd_i.addr == `PMOC_OPERATION_ADDR && !cmd_i.wr;
	endsequence

	op_readback_a: assert property (
		s_wr_op ##1 s_rd_op |=> rd_data_o == ($past(cmd_i.data, 2)
		& 8'hFC)) else $error("operation readback mismatch");

	read_answer_a: assert property (
		cmd_i.rd |=> rd_valid_o) else $error("read not answered");

	hard_off_a: assert property (
		(state == PMOC_ON && next_state == PMOC_OFF) |=> pwm_tri_o
		&& !out_en_o) else $error("immediate off delayed");

	ignore_op_a: assert property (
		(cfg[4] && !cfg[3] && !cfg[2] && state == PMOC_OFF) |=> state
		== PMOC_ON) else $error("on/off bit not ignored");

	need_pin_a: assert property (
		(cfg[4] && cfg[2] && !en_sync[1] && state == PMOC_OFF)
		|=> state == PMOC_OFF) else $error("started without pin");

	op_start_a: assert property (
		(state == PMOC_OFF && cfg[4] && cfg[3] && !cfg[2] && op.on_req)
		|=> out_en_o && !pwm_tri_o) else $error("on request not served");

	soft_ramp_a: assert property (
		(state == PMOC_ON && !run_req && op.soft_off && !op.on_req
		&& cfg[3]) |=> soft_off_o && !pwm_tri_o)
		else $error("soft off not honoured");

	sequence s_ramp_end;
		state == PMOC_RAMP_DOWN && !run_req && ramp_done_i;
	endsequence

	ramp_exit_a: assert property (
		s_ramp_end |=> !out_en_o && pwm_tri_o && !soft_off_o)
		else $error("ramp end not honoured");

	shadow_copy_a: assert property (
		(state != PMOC_OFF && next_state == PMOC_OFF) |=> active_cfg_o
		== $past(shadow_i)) else $error("shadow not applied");

	shadow_hold_a: assert property (
		(state == PMOC_ON && next_state == PMOC_ON) |=> $stable(
		active_cfg_o)) else $error("setting changed while enabled");

	vsel_pick_a: assert property (
		(s_wr_op and cmd_i.data[5:4] != 2'b11) |=> vsel_o ==
		$past(cmd_i.data[5:4])) else $error("voltage target wrong");

	vsel_keep_a: assert property (
		(s_wr_op and cmd_i.data[5:4] == 2'b11) |=> $stable(vsel_o))
		else $error("unused voltage code applied");

	margin_act_a: assert property (
		(s_wr_op and cmd_i.data[3:2] == `PMOC_MFLT_ACT) |=> margin_act_o)
		else $error("margin faults not acted on");

	margin_ignore_a: assert property (
		(s_wr_op and cmd_i.data[3:2] == `PMOC_MFLT_IGNORE)
		|=> !margin_act_o) else $error("margin faults not ignored");
endmodule

// ---- tb/pmoc_host.sv ----
// Host model issuing single-byte command accesses
`timescale 1ns/1ns
module pmoc_host #(
	parameter int GAP = 2                     // Scaled pacing gap
) (
	input  wire logic           clk_i,        // Clock
	output pmoc_pkg::pmoc_cmd_t cmd_o         // Command access
);
	import pmoc_pkg::*;
	initial cmd_o = '0;
	task automatic send(input logic w, input logic [7:0] a,
		input logic [7:0] d);
		@(negedge clk_i) cmd_o = {w, !w, a, d};
		// Released bus shows inverted values, not stale ones
		@(negedge clk_i) cmd_o = {1'b0, 1'b0, ~a, ~d};
		repeat (GAP) @(negedge clk_i);
	endtask
	// Write then read on the next cycle, back to back
	task automatic wr_rd(input logic [7:0] a, input logic [7:0] d);
		@(negedge clk_i) cmd_o = {1'b1, 1'b0, a, d};
		@(negedge clk_i) cmd_o = {1'b0, 1'b1, a, ~d};
		@(negedge clk_i) cmd_o = {1'b0, 1'b0, ~a, d};
		repeat (GAP) @(negedge clk_i);
	endtask
endmodule

// ---- tb/pmoc_operation_control_tb.sv ----
// Self-checking bench for the operation control block
`timescale 1ns/1ns
module pmoc_operation_control_tb;
	import pmoc_pkg::*;
	logic        clk_i = 0, reset_i = 1, en_pin_i = 0, ramp_done_i = 0;
	logic [15:0] shadow_i = '0;
	logic [15:0] active_cfg_o;
	pmoc_cmd_t   cmd_i;
	logic [7:0]  rd_data_o;
	logic        rd_valid_o, out_en_o, pwm_tri_o, soft_off_o, margin_act_o;
	logic [1:0]  vsel_o;
	logic [7:0]  exp_q[$];
	int          n_fail = 0, compares = 0;
	always #10 clk_i = ~clk_i;
	pmoc_host pmoc_host_i (.clk_i, .cmd_o(cmd_i));
	pmoc_operation_control pmoc_operation_control_i (.clk_i, .reset_i,
		.cmd_i, .en_pin_i, .ramp_done_i, .shadow_i, .rd_data_o, .rd_valid_o,
		.out_en_o, .pwm_tri_o, .soft_off_o, .vsel_o, .margin_act_o,
		.active_cfg_o);
	task automatic chk(input logic [15:0] got, input logic [15:0] want);
		compares++;
		if (got !== want) begin
			n_fail++;
			$display("mismatch at %0t: got %h want %h", $time, got, want);
		end
	endtask
	task automatic summarize();
		if (n_fail == 0 && compares > 0)
			$display("No errors found");
		else
			$display("Errors were found");
		$finish;
	endtask
	task automatic rd(input logic [7:0] d);
		exp_q.push_back(d);
		pmoc_host_i.send(1'b0, 8'h01, d);
	endtask
	task automatic op(input logic [7:0] d);
		pmoc_host_i.send(1'b1, 8'h01, d);
	endtask
	// Read answers are matched oldest first
	always @(negedge clk_i) begin
		if (rd_valid_o === 1'b1) begin
			if (exp_q.size() == 0)
				chk(16'hdead, 16'h0000);
			else
				chk({8'h00, rd_data_o}, {8'h00, exp_q.pop_front()});
		end
	end
	initial begin
		int k;
		logic [7:0] d;
		void'($urandom(95));
		repeat (10) @(posedge clk_i);
		@(negedge clk_i) reset_i = 0;
		rd(8'h00);
		chk(16'({out_en_o, pwm_tri_o}), 16'h0001);
		pmoc_host_i.send(1'b1, 8'h02, 8'h10);
		chk(16'(out_en_o), 16'h0001);
		pmoc_host_i.send(1'b1, 8'h02, 8'h18);
		op(8'h97);
		chk(16'({out_en_o, pwm_tri_o, vsel_o, margin_act_o}), 16'h0012);
		rd(8'h94);
		for (int i = 0; i < 3; i++) begin
			op(8'(8'h80 + i * 16 + (i % 2 + 1) * 4));
			chk(16'({vsel_o, margin_act_o}), 16'(i * 2 + i % 2));
		end
		op(8'hbc);
		chk(16'({vsel_o, margin_act_o}), 16'h0004);
		shadow_i = 16'($urandom);
		repeat (3) @(negedge clk_i);
		chk(active_cfg_o, 16'h0000);
		op(8'h00);
		chk(16'({out_en_o, pwm_tri_o}), 16'h0001);
		chk(active_cfg_o, shadow_i);
		op(8'hc0);
		chk(16'({out_en_o, soft_off_o}), 16'h0002);
		shadow_i = 16'($urandom);
		op(8'h40);
		chk(16'({out_en_o, soft_off_o}), 16'h0003);
		@(negedge clk_i) ramp_done_i = 1;
		@(negedge clk_i) ramp_done_i = 0;
		repeat (2) @(negedge clk_i);
		chk(16'({out_en_o, pwm_tri_o, soft_off_o}), 16'h0002);
		chk(active_cfg_o, shadow_i);
		pmoc_host_i.send(1'b1, 8'h02, 8'h14);
		chk(16'(out_en_o), 16'h0000);
		en_pin_i = 1;
		for (k = 0; k < 10 && out_en_o !== 1'b1; k++)
			@(negedge clk_i);
		chk(16'(out_en_o), 16'h0001);
		d = 8'($urandom);
		exp_q.push_back(d & 8'hfc);
		pmoc_host_i.wr_rd(8'h01, d);
		repeat (5) @(negedge clk_i);
		chk(16'(exp_q.size()), 16'h0000);
		summarize();
	end
endmodule
